// ===== core/usb_host_xact_setup.sv
// Transaction setup registers and per-transaction steering for the USB host
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/10ps
module usb_host_xact_setup
  import usb_host_xact_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Transaction engine handshake
  input  wire logic        xact_start_i,
  input  wire logic        xact_end_i,
  input  wire logic        xact_ok_i,
  input  wire logic        xact_is_in_i,
  output logic             xact_busy_o,
  // Token and data stage settings
  output logic [3:0]       token_pid_field_o,
  output logic [3:0]       target_endpoint_field_o,
  output logic [7:0]       tx_byte_count_o,
  output logic [3:0]       tx_data_pid_o,
  output logic [3:0]       rx_expected_pid_o,
  output logic             rx_send_ack_o,
  output logic             tx_expect_ack_o,
  // Buffer half selection
  output logic             tx_buf_second_half_o,
  output logic             rx_buf_second_half_o,
  output logic [6:0]       tx_buf_offset_o,
  output logic [6:0]       rx_buf_offset_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Offsets, field positions and the buffer size all come from the package.
  // A bad edit there would break decode without any symptom, so refuse it.
  if (HALF_BUF_BYTES < 1 || HALF_BUF_BYTES > 127) begin : g_bad_half
    $error("half buffer size does not fit the offset outputs");
  end

  // The bus decode relies on word-aligned offsets
  if (OFS_TOKEN_SELECT[1:0] != 2'b00 || OFS_RX_CONTROL[1:0] != 2'b00 ||
      OFS_TX_LENGTH[1:0] != 2'b00 || OFS_TX_CONTROL[1:0] != 2'b00) begin : g_bad_align
    $error("register offsets must be word aligned");
  end

  if (OFS_TOKEN_SELECT == OFS_RX_CONTROL || OFS_TOKEN_SELECT == OFS_TX_LENGTH ||
      OFS_TOKEN_SELECT == OFS_TX_CONTROL || OFS_RX_CONTROL == OFS_TX_LENGTH ||
      OFS_RX_CONTROL == OFS_TX_CONTROL || OFS_TX_LENGTH == OFS_TX_CONTROL) begin : g_bad_ofs
    $error("register offsets must be distinct");
  end

  if (RX_SEQ_BIT > 7 || RX_AUTO_BIT > 7 || RX_NOHS_BIT > 7 || TX_SEQ_BIT > 7 ||
      TX_AUTO_BIT > 7 || TX_NOHS_BIT > 7) begin : g_bad_field
    $error("control fields must sit in byte lane 0");
  end

  // Masks and field positions must describe the same bits
  if (RX_CTRL_MASK != ((8'h01 << RX_SEQ_BIT) | (8'h01 << RX_AUTO_BIT) |
                       (8'h01 << RX_NOHS_BIT))) begin : g_bad_rx_mask
    $error("receive control mask disagrees with its fields");
  end

  if (TX_CTRL_MASK != ((8'h01 << TX_SEQ_BIT) | (8'h01 << TX_AUTO_BIT) |
                       (8'h01 << TX_NOHS_BIT))) begin : g_bad_tx_mask
    $error("transmit control mask disagrees with its fields");
  end

  if (TX_DBUF_BIT > 7 || RX_DBUF_BIT > 7 || TX_DBUF_BIT == RX_DBUF_BIT ||
      BUF_MODE_MASK != ((8'h01 << TX_DBUF_BIT) | (8'h01 << RX_DBUF_BIT))) begin : g_bad_dbuf
    $error("buffer mode bits must be two distinct bits of byte lane 1");
  end

  if (PID_DATA0 == PID_DATA1) begin : g_bad_pid
    $error("the two data packet identifiers must differ");
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  logic req;
  logic wr_lane0;
  logic mapped;

  // Masking with the answer keeps a held request from being taken twice
  assign req      = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_lane0 = req && we_i && sel_i[0];
  assign mapped   = hit(adr_i, OFS_TOKEN_SELECT) || hit(adr_i, OFS_RX_CONTROL) ||
                    hit(adr_i, OFS_TX_LENGTH) || hit(adr_i, OFS_TX_CONTROL);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] host_token_select;
  logic [7:0] host_transmit_length;
  logic       rx_sequence_auto_flip;
  logic       rx_handshake_suppress;
  logic       tx_sequence_auto_flip;
  logic       tx_handshake_none_expected;
  logic       rx_expected_sequence;
  logic       tx_sequence;
  logic       tx_double_buffer_select;
  logic       rx_double_buffer_select;
  logic       rx_ok;
  logic       tx_ok;
  xact_state_t state;

  // Software must program the length before each OUT; reset value is a convenience only
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_token_select    <= TOKEN_RESET;
      host_transmit_length <= TX_LEN_RESET;
    end else if (wr_lane0) begin
      if (hit(adr_i, OFS_TOKEN_SELECT)) begin
        host_token_select <= dat_i[7:0];
      end
      if (hit(adr_i, OFS_TX_LENGTH)) begin
        host_transmit_length <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sequence_auto_flip <= RX_CTRL_RESET[RX_AUTO_BIT];
      rx_handshake_suppress <= RX_CTRL_RESET[RX_NOHS_BIT];
    end else if (wr_lane0 && hit(adr_i, OFS_RX_CONTROL)) begin
      rx_sequence_auto_flip <= dat_i[RX_AUTO_BIT];
      rx_handshake_suppress <= dat_i[RX_NOHS_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sequence_auto_flip      <= TX_CTRL_RESET[TX_AUTO_BIT];
      tx_handshake_none_expected <= TX_CTRL_RESET[TX_NOHS_BIT];
    end else if (wr_lane0 && hit(adr_i, OFS_TX_CONTROL)) begin
      tx_sequence_auto_flip      <= dat_i[TX_AUTO_BIT];
      tx_handshake_none_expected <= dat_i[TX_NOHS_BIT];
    end
  end

  // Buffer mode bits live in byte lane 1 of the token word
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_double_buffer_select <= 1'b0;
      rx_double_buffer_select <= 1'b0;
    end else if (req && we_i && sel_i[1] && hit(adr_i, OFS_BUF_MODE)) begin
      tx_double_buffer_select <= dat_i[8 + TX_DBUF_BIT];
      rx_double_buffer_select <= dat_i[8 + RX_DBUF_BIT];
    end
  end

  // ****************************************************************
  // Sequence bits
  // ****************************************************************
  // Only a good end of the matching direction counts as success
  assign rx_ok = xact_end_i && xact_ok_i && xact_is_in_i && (state == XS_BUSY);
  assign tx_ok = xact_end_i && xact_ok_i && !xact_is_in_i && (state == XS_BUSY);

  usb_host_seq_bit u_rx_seq (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .sw_we_i     (wr_lane0 && hit(adr_i, OFS_RX_CONTROL)),
    .sw_value_i  (dat_i[RX_SEQ_BIT]),
    .auto_flip_i (rx_sequence_auto_flip),
    .success_i   (rx_ok),
    .seq_o       (rx_expected_sequence)
  );

  usb_host_seq_bit u_tx_seq (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .sw_we_i     (wr_lane0 && hit(adr_i, OFS_TX_CONTROL)),
    .sw_value_i  (dat_i[TX_SEQ_BIT]),
    .auto_flip_i (tx_sequence_auto_flip),
    .success_i   (tx_ok),
    .seq_o       (tx_sequence)
  );

  // ****************************************************************
  // Transaction tracking
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= XS_IDLE;
    end else begin
      unique case (state)
        XS_IDLE: begin
          if (xact_start_i) begin
            state <= XS_BUSY;
          end
        end
        XS_BUSY: begin
          if (xact_end_i) begin
            state <= XS_DONE;
          end
        end
        XS_DONE: begin
          state <= XS_IDLE;
        end
        default: begin
          state <= XS_IDLE;
        end
      endcase
    end
  end

  assign xact_busy_o = (state == XS_BUSY);

  // ****************************************************************
  // Settings presented to the packet engine
  // ****************************************************************
  // Every setting is a flop, so the engine sees a value one cycle after the
  // register or sequence bit moves; it must not latch them in that cycle.

  function automatic logic [3:0] data_pid(input logic seq);
    data_pid = seq ? PID_DATA1 : PID_DATA0;
  endfunction

  function automatic logic second_half(input logic dbuf, input logic seq);
    second_half = dbuf && seq;
  endfunction

  // Token fields
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      token_pid_field_o       <= 4'h0;
      target_endpoint_field_o <= 4'h0;
    end else begin
      token_pid_field_o       <= host_token_select[7:4];
      target_endpoint_field_o <= host_token_select[3:0];
    end
  end

  // Data stage length
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_byte_count_o <= 8'h00;
    end else begin
      tx_byte_count_o <= host_transmit_length;
    end
  end

  // Data packet identifiers
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_data_pid_o     <= PID_DATA0;
      rx_expected_pid_o <= PID_DATA0;
    end else begin
      tx_data_pid_o     <= data_pid(tx_sequence);
      rx_expected_pid_o <= data_pid(rx_expected_sequence);
    end
  end

  // Handshake policy
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_send_ack_o   <= 1'b1;
      tx_expect_ack_o <= 1'b1;
    end else begin
      rx_send_ack_o   <= !rx_handshake_suppress;
      tx_expect_ack_o <= !tx_handshake_none_expected;
    end
  end

  // Transmit buffer half
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_buf_second_half_o <= 1'b0;
      tx_buf_offset_o      <= 7'h00;
    end else begin
      tx_buf_second_half_o <= second_half(tx_double_buffer_select, tx_sequence);
      tx_buf_offset_o      <= second_half(tx_double_buffer_select, tx_sequence) ?
                              7'(HALF_BUF_BYTES) : 7'h00;
    end
  end

  // Receive buffer half
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_buf_second_half_o <= 1'b0;
      rx_buf_offset_o      <= 7'h00;
    end else begin
      rx_buf_second_half_o <= second_half(rx_double_buffer_select, rx_expected_sequence);
      rx_buf_offset_o      <= second_half(rx_double_buffer_select, rx_expected_sequence) ?
                              7'(HALF_BUF_BYTES) : 7'h00;
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  logic [7:0] next_rd0;
  logic [7:0] next_rd1;

  always_comb begin
    next_rd0 = 8'h00;
    next_rd1 = 8'h00;
    if (hit(adr_i, OFS_TOKEN_SELECT)) begin
      next_rd0 = host_token_select;
      next_rd1 = 8'h00;
      next_rd1[TX_DBUF_BIT] = tx_double_buffer_select;
      next_rd1[RX_DBUF_BIT] = rx_double_buffer_select;
    end else if (hit(adr_i, OFS_RX_CONTROL)) begin
      next_rd0[RX_SEQ_BIT]  = rx_expected_sequence;
      next_rd0[RX_AUTO_BIT] = rx_sequence_auto_flip;
      next_rd0[RX_NOHS_BIT] = rx_handshake_suppress;
    end else if (hit(adr_i, OFS_TX_LENGTH)) begin
      next_rd0 = host_transmit_length;
    end else if (hit(adr_i, OFS_TX_CONTROL)) begin
      next_rd0[TX_SEQ_BIT]  = tx_sequence;
      next_rd0[TX_AUTO_BIT] = tx_sequence_auto_flip;
      next_rd0[TX_NOHS_BIT] = tx_handshake_none_expected;
    end
  end

  // One wait state: ack or err comes the edge after the request is seen, drops next.
  // Read data is loaded only on reads, so it stays put for a slow master.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      if (req && !we_i) begin
        dat_o <= {16'h0000, next_rd1, next_rd0};
      end
    end
  end

endmodule

// ===== core/usb_host_xact_pkg.sv
// Constants for the USB host transaction setup block
// What this block does
// - Token PID comes from bits 7:4 of host_token_select.
// - Endpoint number comes from bits 3:0 of host_token_select.
// - IN data expected as DATA1 when rx_expected_sequence is one, else DATA0.
// - rx_sequence_auto_flip inverts the expected receive sequence after good reception.
// - rx_handshake_suppress set sends no handshake for IN data; cleared sends ACK.
// - SETUP/OUT data stage sends host_transmit_length bytes; register resets to zero.
// - SETUP/OUT data sent as DATA1 when tx_sequence is one, else DATA0.
// - tx_sequence_auto_flip inverts tx_sequence after data is sent successfully.
// - tx_handshake_none_expected set expects no handshake; cleared expects ACK.
// - Double-buffer mode picks first 64-byte half on sequence zero, second on one.
package usb_host_xact_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [3:0] OFS_TOKEN_SELECT = 4'h0;
  localparam logic [3:0] OFS_RX_CONTROL   = 4'h4;
  localparam logic [3:0] OFS_TX_LENGTH    = 4'h8;
  localparam logic [3:0] OFS_TX_CONTROL   = 4'hc;
  localparam logic [3:0] OFS_BUF_MODE     = 4'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RX_SEQ_BIT      = 7;
  localparam int RX_AUTO_BIT     = 4;
  localparam int RX_NOHS_BIT     = 2;
  localparam int TX_SEQ_BIT      = 6;
  localparam int TX_AUTO_BIT     = 4;
  localparam int TX_NOHS_BIT     = 0;
  localparam int TX_DBUF_BIT     = 4;
  localparam int RX_DBUF_BIT     = 0;

  localparam logic [7:0] RX_CTRL_MASK  = 8'h94;
  localparam logic [7:0] TX_CTRL_MASK  = 8'h51;
  localparam logic [7:0] BUF_MODE_MASK = 8'h11;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] TOKEN_RESET   = 8'h00;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_LEN_RESET  = 8'h00;

  // ****************************************************************
  // USB packet identifiers and buffer geometry
  // ****************************************************************
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hb;
  localparam logic [3:0] PID_ACK   = 4'h2;
  localparam int         HALF_BUF_BYTES = 64;

  typedef enum logic [2:0] {
    XS_IDLE = 3'b001,
    XS_BUSY = 3'b010,
    XS_DONE = 3'b100
  } xact_state_t;

endpackage

// ===== core/usb_host_seq_bit.sv
// One sequence bit with software write and hardware auto flip
`timescale 1ns/10ps
module usb_host_seq_bit (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // Software write
  input  wire logic sw_we_i,
  input  wire logic sw_value_i,
  // Hardware events
  input  wire logic auto_flip_i,
  input  wire logic success_i,
  // State
  output logic      seq_o
);

  // Hardware flip wins over a same-cycle write; a failed end never touches the bit
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_o <= 1'b0;
    end else if (success_i && auto_flip_i) begin
      seq_o <= ~seq_o;
    end else if (sw_we_i) begin
      seq_o <= sw_value_i;
    end
  end

endmodule

// ===== sim/usb_host_xact_setup_checker.sv
// Concurrent checks on the ports of the transaction setup block
`timescale 1ns/10ps
module usb_host_xact_setup_checker
  import usb_host_xact_pkg::*;
(
  // Clock, reset and bus
  input wire logic        ref_clk_i, reset_n_i, cyc_i, stb_i, we_i, ack_o, err_o,
  input wire logic [3:0]  adr_i, sel_i,
  input wire logic [31:0] dat_i,
  // Engine handshake and settings
  input wire logic        xact_start_i, xact_end_i, xact_ok_i, xact_is_in_i, xact_busy_o,
  input wire logic [3:0]  token_pid_field_o, target_endpoint_field_o,
  input wire logic [3:0]  tx_data_pid_o, rx_expected_pid_o,
  input wire logic        tx_buf_second_half_o, rx_buf_second_half_o,
  input wire logic [6:0]  tx_buf_offset_o, rx_buf_offset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire idle_bus = !(cyc_i && stb_i);

  answer_once_a: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
    else $error("bus answer held longer than one cycle");
  mapped_ack_a: assert property (req && adr_i[1:0] == 2'b00 |=> ack_o && !err_o)
    else $error("mapped access not acknowledged next cycle");
  unmapped_err_a: assert property (req && adr_i[1:0] != 2'b00 |=> err_o && !ack_o)
    else $error("unmapped access not refused next cycle");
  token_copy_a: assert property (
    req && we_i && adr_i == OFS_TOKEN_SELECT && sel_i[0] |=> ##1
      token_pid_field_o == $past(dat_i[7:4], 2) && target_endpoint_field_o == $past(dat_i[3:0], 2))
    else $error("token fields do not follow the write");
  tx_half_a: assert property (
    tx_buf_offset_o == (tx_buf_second_half_o ? 7'h40 : 7'h00)
      && (!tx_buf_second_half_o || tx_data_pid_o == PID_DATA1))
    else $error("transmit buffer half wrong");
  rx_half_a: assert property (
    rx_buf_offset_o == (rx_buf_second_half_o ? 7'h40 : 7'h00)
      && (!rx_buf_second_half_o || rx_expected_pid_o == PID_DATA1))
    else $error("receive buffer half wrong");
  fail_keep_a: assert property (
    xact_end_i && !xact_ok_i && idle_bus |=> ##1 $stable(tx_data_pid_o) && $stable(rx_expected_pid_o))
    else $error("sequence changed after failed transaction");
  in_keeps_tx_a: assert property (xact_end_i && xact_is_in_i && idle_bus |=> ##1 $stable(tx_data_pid_o))
    else $error("transmit sequence changed by IN transaction");
  out_keeps_rx_a: assert property (xact_end_i && !xact_is_in_i && idle_bus |=> ##1 $stable(rx_expected_pid_o))
    else $error("receive sequence changed by OUT transaction");
  busy_start_a: assert property (xact_start_i && !xact_busy_o && !$past(xact_busy_o) |=> xact_busy_o)
    else $error("busy did not rise after start");
  busy_hold_a: assert property (xact_busy_o |=> xact_busy_o == !$past(xact_end_i))
    else $error("busy did not follow end");
endmodule

// ===== sim/usb_xact_engine_model.sv
// Behavioural transaction engine that drives the handshake lines of the setup block
`timescale 1ns/10ps
module usb_xact_engine_model (
  // Clock
  input wire logic ref_clk_i,
  // Handshake towards the setup block
  output logic     start_o,
  output logic     end_o,
  output logic     ok_o,
  output logic     is_in_o
);
  initial begin
    start_o = 1'b0;
    end_o = 1'b0;
    ok_o = 1'b0;
    is_in_o = 1'b0;
  end

  // Outcome lines are only valid with end, so they show the inverse otherwise
  task automatic run(input logic is_in, input logic ok, input int gap);
    @(posedge ref_clk_i);
    start_o <= 1'b1;
    @(posedge ref_clk_i);
    start_o <= 1'b0;
    repeat (gap) @(posedge ref_clk_i);
    end_o <= 1'b1;
    ok_o <= ok;
    is_in_o <= is_in;
    @(posedge ref_clk_i);
    end_o <= 1'b0;
    ok_o <= ~ok;
    is_in_o <= ~is_in;
  endtask
endmodule

// ===== sim/usb_host_xact_setup_test.sv
// Self-checking testbench for the transaction setup block
`timescale 1ns/10ps
module usb_host_xact_setup_test;
  import usb_host_xact_pkg::*;
  logic        ref_clk_i, reset_n_i, cyc_i, stb_i, we_i, ack_o, err_o, last_err;
  logic [3:0]  adr_i, sel_i, token_pid_field_o, target_endpoint_field_o;
  logic [31:0] dat_i, dat_o, q;
  logic        xact_start_i, xact_end_i, xact_ok_i, xact_is_in_i, xact_busy_o;
  logic [3:0]  tx_data_pid_o, rx_expected_pid_o;
  logic [7:0]  tx_byte_count_o;
  logic        rx_send_ack_o, tx_expect_ack_o, tx_buf_second_half_o, rx_buf_second_half_o;
  logic [6:0]  tx_buf_offset_o, rx_buf_offset_o;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  usb_host_xact_setup uut (.*);
  usb_xact_engine_model eng (.ref_clk_i, .start_o(xact_start_i), .end_o(xact_end_i),
                             .ok_o(xact_ok_i), .is_in_o(xact_is_in_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A run of roughly a hundred cycles; the ceiling leaves ample margin
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (!(ack_o || err_o) && n < 20);
    if (!(ack_o || err_o)) chk("bus answer", 32'h1, 32'h0);
    r = dat_o;
    last_err = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hf, 32'h0, q);
    chk("read data", exp, q);
  endtask

  task automatic pids(input logic [3:0] t, input logic [3:0] r);
    repeat (2) @(negedge ref_clk_i);
    chk("data pids", 32'({tx_data_pid_o, rx_expected_pid_o}), 32'({t, r}));
  endtask

  initial begin
    {reset_n_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(OFS_TOKEN_SELECT, 32'h0);
    rd(OFS_RX_CONTROL, 32'h0);
    rd(OFS_TX_LENGTH, 32'h0);
    rd(OFS_TX_CONTROL, 32'h0);
    pids(PID_DATA0, PID_DATA0);
    chk("acks", 32'({rx_send_ack_o, tx_expect_ack_o}), 32'h3);
    wr(OFS_TOKEN_SELECT, 32'h11d5);
    rd(OFS_TOKEN_SELECT, 32'h11d5);
    chk("token", 32'({token_pid_field_o, target_endpoint_field_o}), 32'hd5);
    wr(OFS_RX_CONTROL, 32'hff);
    rd(OFS_RX_CONTROL, 32'h94);
    wr(OFS_TX_CONTROL, 32'hff);
    rd(OFS_TX_CONTROL, 32'h51);
    pids(PID_DATA1, PID_DATA1);
    chk("acks", 32'({rx_send_ack_o, tx_expect_ack_o}), 32'h0);
    chk("halves", 32'({tx_buf_second_half_o, rx_buf_second_half_o, tx_buf_offset_o,
        rx_buf_offset_o}), 32'({2'b11, 7'(HALF_BUF_BYTES), 7'(HALF_BUF_BYTES)}));
    wr(OFS_TX_LENGTH, 32'ha7);
    wb(1'b1, OFS_TX_LENGTH, 4'he, 32'h12, q);
    rd(OFS_TX_LENGTH, 32'ha7);
    chk("length", 32'(tx_byte_count_o), 32'ha7);
    wb(1'b0, 4'h2, 4'hf, 32'h0, q);
    chk("bus error", 32'(last_err), 32'h1);
    eng.run(1'b0, 1'b1, 0);
    pids(PID_DATA0, PID_DATA1);
    eng.run(1'b1, 1'b1, 5);
    pids(PID_DATA0, PID_DATA0);
    eng.run(1'b1, 1'b0, 5);
    eng.run(1'b0, 1'b0, 0);
    pids(PID_DATA0, PID_DATA0);
    chk("halves", 32'({tx_buf_second_half_o, rx_buf_second_half_o}), 32'h0);
    wr(OFS_TX_CONTROL, 32'h40);
    wr(OFS_RX_CONTROL, 32'h80);
    eng.run(1'b0, 1'b1, 0);
    eng.run(1'b1, 1'b1, 0);
    pids(PID_DATA1, PID_DATA1);
    chk("acks", 32'({rx_send_ack_o, tx_expect_ack_o}), 32'h3);
    test_done();
  end
endmodule

bind usb_host_xact_setup usb_host_xact_setup_checker chk_i (.ref_clk_i, .reset_n_i, .cyc_i,
  .stb_i, .we_i, .ack_o, .err_o, .adr_i, .sel_i, .dat_i, .xact_start_i, .xact_end_i,
  .xact_ok_i, .xact_is_in_i, .xact_busy_o, .token_pid_field_o, .target_endpoint_field_o,
  .tx_data_pid_o, .rx_expected_pid_o, .tx_buf_second_half_o, .rx_buf_second_half_o,
  .tx_buf_offset_o, .rx_buf_offset_o);
